// File: core/fix_report_pkg.sv
/*
  Shared constants for the fix and tracking report link: framing bytes,
  field offsets, status codes, health bit positions, timing and the
  host-side register map.
  Assumes a single 40 MHz system clock shared by both ends.
*/
package fix_report_pkg;

  // ==========================================================
  // Framing
  localparam int unsigned FRAME_LEN = 168;
  localparam int unsigned HDR_LEN   = 2;
  localparam logic [7:0]  DLE_BYTE  = 8'h10;
  localparam logic [7:0]  ETX_BYTE  = 8'h03;
  localparam logic [7:0]  REPORT_ID = 8'h8F;
  localparam logic [7:0]  SUB_CODE  = 8'h2A;
  localparam logic [7:0]  RSVD_BYTE = 8'h00;

  // ==========================================================
  // Data field offsets
  localparam int unsigned OFS_WEEK   = 3;
  localparam int unsigned OFS_MSEC   = 5;
  localparam int unsigned OFS_FRAC   = 9;
  localparam int unsigned OFS_ALT    = 13;
  localparam int unsigned OFS_STAT   = 17;
  localparam int unsigned OFS_HEALTH = 18;

  // ==========================================================
  // Field limits and codes
  localparam logic [31:0] MSEC_MAX   = 32'd603799999;
  localparam logic [31:0] FRAC_MAX   = 32'd500000;
  localparam logic [63:0] NS_PER_MS  = 64'd1000000;
  localparam logic [7:0]  ST_FIXING  = 8'h00;
  localparam logic [7:0]  ST_NO_TIME = 8'h01;
  localparam logic [7:0]  ST_PDOP    = 8'h03;
  localparam logic [7:0]  ST_SV0     = 8'h08;
  localparam logic [7:0]  ST_SV3     = 8'h0B;

  // ==========================================================
  // Health bit positions
  localparam int unsigned HB_ANT_FAULT = 0;
  localparam int unsigned HB_ANT_SHORT = 1;
  localparam int unsigned HB_FIX_2D    = 2;
  localparam int unsigned HB_AUGMENTED = 3;
  localparam int unsigned HB_MEM_MISS  = 4;
  localparam int unsigned HB_RTC_MISS  = 5;
  localparam int unsigned HB_ALM_STALE = 6;
  localparam int unsigned HB_BIAS_UNK  = 7;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned AUTO_PERIOD_MS  = 1000;
  localparam int unsigned AUTO_PERIOD_CYC = CLK_HZ / 1000 * AUTO_PERIOD_MS;

  // ==========================================================
  // Host register map
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_MASK    = 8'h08;
  localparam logic [7:0]  REG_WEEK    = 8'h0C;
  localparam logic [7:0]  REG_MSEC    = 8'h10;
  localparam logic [7:0]  REG_FRAC    = 8'h14;
  localparam logic [7:0]  REG_ALT     = 8'h18;
  localparam logic [7:0]  REG_COND    = 8'h1C;
  localparam logic [7:0]  REG_TIME_LO = 8'h20;
  localparam logic [7:0]  REG_TIME_HI = 8'h24;
  localparam int unsigned CTRL_REQ    = 0;
  localparam int unsigned CTRL_AUTO   = 1;
  localparam int unsigned EV_FRAME    = 0;
  localparam int unsigned EV_ERROR    = 1;
  localparam int unsigned COND_FIXOK  = 16;
  localparam int unsigned COND_FRACOK = 17;
  localparam int unsigned COND_SHORTOK = 18;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;

  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;

endpackage

// File: core/fix_link_if.sv
/*
  Byte link between the report framer and the host controller,
  plus the host's request and automatic-output command lines.
  Assumes both ends run on the same clock; the bench joins them.
*/
`timescale 1ns/10ps
interface fix_link_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  logic       reqOnce;
  logic       autoEn;

  modport dev (
    output data,
    output valid,
    input  ready,
    input  reqOnce,
    input  autoEn
  );

  modport host (
    input  data,
    input  valid,
    output ready,
    output reqOnce,
    output autoEn
  );
endinterface

// File: core/fix_report_framer.sv
/*
  Device end: snapshots the measurement and receiver condition, then
  sends one 168-byte report frame over the byte link, on request or
  on a periodic timer.
  Assumes field inputs come from logic on clk_sys and stay valid
  while a request is pending; byte stuffing is done further out.
*/
`timescale 1ns/10ps
module fix_report_framer
  import fix_report_pkg::*;
#(
  parameter int unsigned AUTO_CYC = AUTO_PERIOD_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  fix_link_if.dev          link,
  input  wire logic [9:0]  weekIn,
  input  wire logic [31:0] msecIn,
  input  wire logic [31:0] fracNsIn,
  input  wire logic [31:0] altitudeIn,
  input  wire logic [7:0]  statusIn,
  input  wire logic        antFault,
  input  wire logic        antShort,
  input  wire logic        fix2d,
  input  wire logic        augmented,
  input  wire logic        battMemMissing,
  input  wire logic        rtcMissing,
  input  wire logic        almanacStale,
  input  wire logic        biasUnknown,
  output logic             busy
);

  // ==========================================================
  // Sequencer state, timer and snapshot values
  tx_state_t   state_r;
  logic [7:0]  idx_r;
  logic [7:0]  data_r;
  logic        valid_r;
  logic        pend_r;
  logic [31:0] timer_r;
  logic        tick;
  logic [15:0] weekSnap_r;
  logic [31:0] msecSnap_r;
  logic [31:0] fracSnap_r;
  logic [31:0] altSnap_r;
  logic [7:0]  statSnap_r;
  logic [7:0]  healthSnap_r;
  logic [31:0] msecClamp;
  logic [31:0] fracClamp;
  logic [7:0]  healthNow;
  logic        fixing;
  logic        start;
  logic        accept;
  logic        last;

  assign link.data  = data_r;
  assign link.valid = valid_r;
  assign busy       = state_r == TX_SEND;

  assign fixing = statusIn == ST_FIXING;
  assign accept = valid_r && link.ready;
  assign last   = idx_r == 8'(FRAME_LEN - 1);
  assign start  = state_r == TX_IDLE && pend_r;

  // Out-of-range millisecond and fraction inputs are clamped so the host never sees a bad time field
  always_comb begin
    msecClamp = (msecIn > MSEC_MAX) ? MSEC_MAX : msecIn;
    fracClamp = fracNsIn;
    if ($signed(fracNsIn) > $signed(FRAC_MAX)) begin
      fracClamp = FRAC_MAX;
    end else if ($signed(fracNsIn) < -$signed(FRAC_MAX)) begin
      fracClamp = -FRAC_MAX;
    end
  end

  // Qualified bits are forced low when their meaning does not hold
  always_comb begin
    healthNow               = 8'h00;
    healthNow[HB_ANT_FAULT] = antFault;
    healthNow[HB_ANT_SHORT] = antFault && antShort;
    healthNow[HB_FIX_2D]    = fixing && fix2d;
    healthNow[HB_AUGMENTED] = fixing && augmented;
    healthNow[HB_MEM_MISS]  = battMemMissing;
    healthNow[HB_RTC_MISS]  = rtcMissing;
    healthNow[HB_ALM_STALE] = almanacStale;
    healthNow[HB_BIAS_UNK]  = biasUnknown;
  end

  // ==========================================================
  // Byte at a frame position
  function automatic logic [7:0] byteAt(input logic [7:0] pos);
    logic [7:0] ofs;
    ofs    = pos - 8'(HDR_LEN);
    byteAt = RSVD_BYTE;
    if (pos == 8'd0) begin
      byteAt = DLE_BYTE;
    end else if (pos == 8'd1) begin
      byteAt = REPORT_ID;
    end else if (pos == 8'(FRAME_LEN - 2)) begin
      byteAt = DLE_BYTE;
    end else if (pos == 8'(FRAME_LEN - 1)) begin
      byteAt = ETX_BYTE;
    end else begin
      case (ofs)
        8'd0:                 byteAt = SUB_CODE;
        8'(OFS_WEEK):         byteAt = weekSnap_r[15:8];
        8'(OFS_WEEK + 1):     byteAt = weekSnap_r[7:0];
        8'(OFS_MSEC):         byteAt = msecSnap_r[31:24];
        8'(OFS_MSEC + 1):     byteAt = msecSnap_r[23:16];
        8'(OFS_MSEC + 2):     byteAt = msecSnap_r[15:8];
        8'(OFS_MSEC + 3):     byteAt = msecSnap_r[7:0];
        8'(OFS_FRAC):         byteAt = fracSnap_r[31:24];
        8'(OFS_FRAC + 1):     byteAt = fracSnap_r[23:16];
        8'(OFS_FRAC + 2):     byteAt = fracSnap_r[15:8];
        8'(OFS_FRAC + 3):     byteAt = fracSnap_r[7:0];
        8'(OFS_ALT):          byteAt = altSnap_r[31:24];
        8'(OFS_ALT + 1):      byteAt = altSnap_r[23:16];
        8'(OFS_ALT + 2):      byteAt = altSnap_r[15:8];
        8'(OFS_ALT + 3):      byteAt = altSnap_r[7:0];
        8'(OFS_STAT):         byteAt = statSnap_r;
        8'(OFS_HEALTH):       byteAt = healthSnap_r;
        default:              byteAt = RSVD_BYTE;
      endcase
    end
  endfunction

  // ==========================================================
  // Periodic output timer
  assign tick = link.autoEn && timer_r == AUTO_CYC - 1;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timer_r <= 32'h0000_0000;
    end else if (!link.autoEn || tick) begin
      timer_r <= 32'h0000_0000;
    end else begin
      timer_r <= timer_r + 32'h0000_0001;
    end
  end

  // A new request during a frame is held, so it is never lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else if (link.reqOnce || tick) begin
      pend_r <= 1'b1;
    end else if (start) begin
      pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // Snapshot at frame start keeps the frame self-consistent
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      weekSnap_r   <= 16'h0000;
      msecSnap_r   <= 32'h0000_0000;
      fracSnap_r   <= 32'h0000_0000;
      altSnap_r    <= 32'h0000_0000;
      statSnap_r   <= 8'h00;
      healthSnap_r <= 8'h00;
    end else if (start) begin
      weekSnap_r   <= {6'h00, weekIn};
      msecSnap_r   <= msecClamp;
      fracSnap_r   <= fracClamp;
      altSnap_r    <= altitudeIn;
      statSnap_r   <= statusIn;
      healthSnap_r <= healthNow;
    end
  end

  // ==========================================================
  // Frame sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= TX_IDLE;
      idx_r   <= 8'h00;
      data_r  <= 8'h00;
      valid_r <= 1'b0;
    end else begin
      case (state_r)
        TX_IDLE: begin
          if (pend_r) begin
            state_r <= TX_SEND;
            idx_r   <= 8'h00;
            data_r  <= DLE_BYTE;
            valid_r <= 1'b1;
          end
        end
        TX_SEND: begin
          if (accept) begin
            if (last) begin
              state_r <= TX_IDLE;
              valid_r <= 1'b0;
              data_r  <= 8'h00;
            end else begin
              idx_r  <= idx_r + 8'h01;
              data_r <= byteAt(idx_r + 8'h01);
            end
          end
        end
        default: begin
          state_r <= TX_IDLE;
          valid_r <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: core/fix_report_host.sv
/*
  Host end: commands the report, parses incoming frames and exposes the
  decoded fix through a small register file with a masked interrupt.
  Assumes the byte link shares clk_sys with the framer.
*/
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module fix_report_host
  import fix_report_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  fix_link_if.host         link,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  output logic             irq
);

  // ==========================================================
  // Storage
  logic [31:0] rdata_r;
  logic        irq_r;
  logic        ready_r;
  logic        req_r;
  logic        auto_r;
  logic [1:0]  events_r;
  logic [1:0]  mask_r;
  logic [7:0]  idx_r;
  logic [15:0] weekCap_r;
  logic [31:0] msecCap_r;
  logic [31:0] fracCap_r;
  logic [31:0] altCap_r;
  logic [7:0]  statCap_r;
  logic [7:0]  healthCap_r;
  logic [15:0] week_r;
  logic [31:0] msec_r;
  logic [31:0] frac_r;
  logic [31:0] alt_r;
  logic [7:0]  stat_r;
  logic [7:0]  health_r;
  logic [63:0] timeNs_r;
  logic [7:0]  ofs;
  logic [7:0]  b;
  logic        take;
  logic        bad;
  logic        done;
  logic [1:0]  evSet;
  logic        fixOk;

  assign link.ready   = ready_r;
  assign link.reqOnce = req_r;
  assign link.autoEn  = auto_r;
  assign regRdata     = rdata_r;
  assign irq          = irq_r;

  assign b    = link.data;
  assign ofs  = idx_r - 8'(HDR_LEN);
  assign take = link.valid && ready_r;
  assign done = take && idx_r == 8'(FRAME_LEN - 1) && b == ETX_BYTE;

  // Only framing bytes and the sub-code are checked; reserved ignored
  always_comb begin
    bad = 1'b0;
    if (take) begin
      case (idx_r)
        8'd1:                  bad = b != REPORT_ID;
        8'd2:                  bad = b != SUB_CODE;
        8'(FRAME_LEN - 2):     bad = b != DLE_BYTE;
        8'(FRAME_LEN - 1):     bad = b != ETX_BYTE;
        default:               bad = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Command lines
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
      req_r   <= 1'b0;
      auto_r  <= 1'b0;
    end else begin
      ready_r <= 1'b1;
      req_r   <= regWr && regAddr == REG_CTRL && regWdata[CTRL_REQ];
      if (regWr && regAddr == REG_CTRL) begin
        auto_r <= regWdata[CTRL_AUTO];
      end
    end
  end

  // ==========================================================
  // Frame parser; hunts for the opening delimiter after an error
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      idx_r <= 8'h00;
    end else if (take) begin
      if (bad || done) begin
        idx_r <= 8'h00;
      end else if (idx_r != 8'h00 || b == DLE_BYTE) begin
        idx_r <= idx_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      weekCap_r   <= 16'h0000;
      msecCap_r   <= 32'h0000_0000;
      fracCap_r   <= 32'h0000_0000;
      altCap_r    <= 32'h0000_0000;
      statCap_r   <= 8'h00;
      healthCap_r <= 8'h00;
    end else if (take && idx_r >= 8'(HDR_LEN)) begin
      if (ofs >= 8'(OFS_WEEK) && ofs < 8'(OFS_MSEC)) begin
        weekCap_r <= {weekCap_r[7:0], b};
      end
      if (ofs >= 8'(OFS_MSEC) && ofs < 8'(OFS_FRAC)) begin
        msecCap_r <= {msecCap_r[23:0], b};
      end
      if (ofs >= 8'(OFS_FRAC) && ofs < 8'(OFS_ALT)) begin
        fracCap_r <= {fracCap_r[23:0], b};
      end
      if (ofs >= 8'(OFS_ALT) && ofs < 8'(OFS_STAT)) begin
        altCap_r <= {altCap_r[23:0], b};
      end
      if (ofs == 8'(OFS_STAT)) begin
        statCap_r <= b;
      end
      if (ofs == 8'(OFS_HEALTH)) begin
        healthCap_r <= b;
      end
    end
  end

  // Published fields change only on a complete, well-framed report
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      week_r   <= 16'h0000;
      msec_r   <= 32'h0000_0000;
      frac_r   <= 32'h0000_0000;
      alt_r    <= 32'h0000_0000;
      stat_r   <= 8'h00;
      health_r <= 8'h00;
      timeNs_r <= 64'h0000_0000_0000_0000;
    end else if (done) begin
      week_r   <= weekCap_r;
      msec_r   <= msecCap_r;
      frac_r   <= fracCap_r;
      alt_r    <= altCap_r;
      stat_r   <= statCap_r;
      health_r <= healthCap_r;
      timeNs_r <= {32'h0000_0000, msecCap_r} * NS_PER_MS
                + {{32{fracCap_r[31]}}, fracCap_r};
    end
  end

  // ==========================================================
  // Events, mask, interrupt; set beats write-one-to-clear
  assign evSet = {bad, done};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      events_r <= 2'b00;
      mask_r   <= 2'b00;
      irq_r    <= 1'b0;
    end else begin
      if (regWr && regAddr == REG_STATUS) begin
        events_r <= (events_r & ~regWdata[1:0]) | evSet;
      end else begin
        events_r <= events_r | evSet;
      end
      if (regWr && regAddr == REG_MASK) begin
        mask_r <= regWdata[1:0];
      end
      irq_r <= |(events_r & mask_r);
    end
  end

  // ==========================================================
  // Read port
  assign fixOk = stat_r == ST_FIXING;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_r <= RST_WORD;
    end else if (regRd) begin
      case (regAddr)
        REG_CTRL:    rdata_r <= {30'h0000_0000, auto_r, 1'b0};
        REG_STATUS:  rdata_r <= {30'h0000_0000, events_r};
        REG_MASK:    rdata_r <= {30'h0000_0000, mask_r};
        REG_WEEK:    rdata_r <= {16'h0000, week_r};
        REG_MSEC:    rdata_r <= msec_r;
        REG_FRAC:    rdata_r <= frac_r;
        REG_ALT:     rdata_r <= alt_r;
        REG_COND:    rdata_r <= {13'h0000,
                                 health_r[HB_ANT_FAULT],
                                 !health_r[HB_BIAS_UNK],
                                 fixOk, health_r, stat_r};
        REG_TIME_LO: rdata_r <= timeNs_r[31:0];
        REG_TIME_HI: rdata_r <= timeNs_r[63:32];
        default:     rdata_r <= RST_WORD;
      endcase
    end else begin
      rdata_r <= RST_WORD;
    end
  end

endmodule

// File: testbench/fix_report_link_chk.sv
/*
  Concurrent checks on the report byte link between framer and host.
  Assumes it sits beside the link interface, on the single system clock.
*/
`timescale 1ns/10ps
module fix_report_link_chk
  import fix_report_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] data,
  input wire logic       valid,
  input wire logic       ready,
  input wire logic       reqOnce,
  input wire logic       autoEn
);
  // ==========================================================
  // Byte index within the frame; needs no reset, idle link clears it
  logic [7:0] byteCnt_r;

  always_ff @(posedge clk_sys) begin
    if (valid && ready) begin
      byteCnt_r <= byteCnt_r + 8'h01;
    end else begin
      byteCnt_r <= 8'h00;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_head;
    $rose(valid) |-> data == DLE_BYTE ##1 data == REPORT_ID ##1 data == 8'h2A;
  endproperty
  a_head: assert property (p_head) else $error("frame header bytes wrong");

  property p_len;
    $fell(valid) && $past(rst_n) |-> byteCnt_r == 8'hA8;
  endproperty
  a_len: assert property (p_len) else $error("frame length wrong");

  property p_tail;
    $fell(valid) && $past(rst_n) |-> $past(data) == ETX_BYTE && $past(data, 2) == DLE_BYTE;
  endproperty
  a_tail: assert property (p_tail) else $error("frame trailer wrong");

  // Auto mode and just-ended frames excluded: a pending start may win
  property p_start;
    reqOnce && !valid && !$past(valid) && !autoEn |-> ##2 valid && data == DLE_BYTE;
  endproperty
  a_start: assert property (p_start) else $error("request did not start frame");

  property p_pulse;
    reqOnce |=> !reqOnce;
  endproperty
  a_pulse: assert property (p_pulse) else $error("request not one cycle");

  property p_pad;
    valid && byteCnt_r >= 8'h15 && byteCnt_r <= 8'hA5 |-> data == 8'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("reserved byte not zero");

  property p_week;
    valid && byteCnt_r == 8'h05 |-> data[7:2] == 6'h00;
  endproperty
  a_week: assert property (p_week) else $error("week above ten bits");

  property p_msec;
    valid && byteCnt_r == 8'h07 |-> data <= 8'h23;
  endproperty
  a_msec: assert property (p_msec) else $error("millisecond out of range");

  property p_short;
    valid && byteCnt_r == 8'h14 |-> !data[1] || data[0];
  endproperty
  a_short: assert property (p_short) else $error("short bit without fault");

  property p_fixbits;
    valid && byteCnt_r == 8'h14 && $past(data) != 8'h00 |-> data[3:2] == 2'b00;
  endproperty
  a_fixbits: assert property (p_fixbits) else $error("fix bits while not fixing");
endmodule

// File: testbench/fix_tracking_report_framer_tb_top.sv
/*
  Bench joining framer and host over the link; drives fields and the
  register port, records every frame byte and compares the latest frame after each wait.
  Assumes the design package and link interface are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin badCount++; \
  $display("FAIL %s exp=%0h got=%0h", nm, e, g); end end
module fix_tracking_report_framer_tb_top
  import fix_report_pkg::*;
;
  localparam int AUTO_SIM = 300;
  localparam int CEILING  = 10000;
  logic        clk_sys, rst_n, regWr, regRd, irq, busy;
  logic [9:0]  weekIn;
  logic [31:0] msecIn, fracNsIn, altitudeIn, regWdata, regRdata;
  logic [7:0]  statusIn, healthIn, regAddr;
  logic [7:0]  expB [168];
  logic [7:0]  gotB [168];
  int          idx, frameCount, lastLen, cycles, badCount, samplesChecked;

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  fix_link_if u_fix_link_if ();
  // Health vector order: fault, short, 2-D, augmented, memory, clock, almanac, bias
  fix_report_framer #(.AUTO_CYC(AUTO_SIM)) u_fix_report_framer (.clk_sys(clk_sys),
    .rst_n(rst_n), .link(u_fix_link_if.dev), .weekIn(weekIn), .msecIn(msecIn),
    .fracNsIn(fracNsIn), .altitudeIn(altitudeIn), .statusIn(statusIn),
    .antFault(healthIn[0]), .antShort(healthIn[1]), .fix2d(healthIn[2]),
    .augmented(healthIn[3]), .battMemMissing(healthIn[4]), .rtcMissing(healthIn[5]),
    .almanacStale(healthIn[6]), .biasUnknown(healthIn[7]), .busy(busy));
  fix_report_host u_fix_report_host (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(u_fix_link_if.host), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .irq(irq));
  fix_report_link_chk u_fix_report_link_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .data(u_fix_link_if.data), .valid(u_fix_link_if.valid), .ready(u_fix_link_if.ready),
    .reqOnce(u_fix_link_if.reqOnce), .autoEn(u_fix_link_if.autoEn));

  // ==========================================================
  // Frame recorder and hang guard
  always @(posedge clk_sys) begin
    if (u_fix_link_if.valid && u_fix_link_if.ready) begin
      if (idx < 168) gotB[idx] = u_fix_link_if.data;
      idx++;
    end else if (idx != 0) begin
      lastLen = idx;
      frameCount++;
      idx = 0;
    end
    cycles++;
    if (cycles == CEILING) begin
      badCount++;
      printVerdict();
    end
  end

  task automatic printVerdict();
    $display("Counts: checked=%0d mismatches=%0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Register port and frame helpers
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic waitFrames(input int n);
    int target;
    target = frameCount + n;
    for (int i = 0; i < 2000 && frameCount < target; i++) @(posedge clk_sys);
    `CHK("frameCount", target, frameCount)
  endtask

  // Expected frame worked out from the field inputs
  task automatic checkFrame();
    logic [7:0]  h;
    logic [31:0] mx;
    logic [31:0] fx;
    // Out-of-range fields must arrive clamped to their documented limits
    mx = (msecIn > MSEC_MAX) ? MSEC_MAX : msecIn;
    fx = fracNsIn;
    if ($signed(fracNsIn) > $signed(FRAC_MAX)) fx = FRAC_MAX;
    if ($signed(fracNsIn) < -$signed(FRAC_MAX)) fx = -FRAC_MAX;
    h = healthIn;
    h[1] = healthIn[0] & healthIn[1];
    h[2] = (statusIn == 8'h00) & healthIn[2];
    h[3] = (statusIn == 8'h00) & healthIn[3];
    foreach (expB[i]) expB[i] = 8'h00;
    expB[0] = DLE_BYTE;
    expB[1] = REPORT_ID;
    expB[2] = 8'h2A;
    {expB[5], expB[6]} = {6'h00, weekIn};
    {expB[7], expB[8], expB[9], expB[10]} = mx;
    {expB[11], expB[12], expB[13], expB[14]} = fx;
    {expB[15], expB[16], expB[17], expB[18]} = altitudeIn;
    expB[19] = statusIn;
    expB[20] = h;
    expB[166] = DLE_BYTE;
    expB[167] = ETX_BYTE;
    `CHK("frameLen", 168, lastLen)
    for (int i = 0; i < 168; i++) `CHK($sformatf("byte%0d", i), expB[i], gotB[i])
  endtask

  // ==========================================================
  // Scenarios
  task automatic tOnce();
    logic [31:0] rd;
    logic [63:0] tns;
    @(posedge clk_sys);
    weekIn <= 10'h3FF;
    msecIn <= 32'h23FD_41BF;
    fracNsIn <= 32'hFFF8_5EE0;
    altitudeIn <= 32'h8123_4567;
    statusIn <= 8'h00;
    healthIn <= 8'hFF;
    regWrite(REG_CTRL, 32'h0000_0001);
    waitFrames(1);
    checkFrame();
    tns = 64'(msecIn) * NS_PER_MS + 64'(signed'(fracNsIn));
    regRead(REG_TIME_LO, rd);
    `CHK("timeLo", tns[31:0], rd)
    regRead(REG_TIME_HI, rd);
    `CHK("timeHi", tns[63:32], rd)
    regRead(REG_WEEK, rd);
    `CHK("week", 32'h0000_03FF, rd)
    regRead(REG_FRAC, rd);
    `CHK("frac", fracNsIn, rd)
    regRead(REG_MSEC, rd);
    `CHK("msec", msecIn, rd)
    regRead(REG_ALT, rd);
    `CHK("alt", altitudeIn, rd)
    regRead(REG_COND, rd);
    `CHK("cond", 32'h0005_FF00, rd)
    `CHK("irqMasked", 1'b0, irq)
    regRead(REG_STATUS, rd);
    `CHK("status", 32'h0000_0001, rd)
    regWrite(REG_MASK, 32'h0000_0001);
    @(posedge clk_sys);
    #1 `CHK("irqSet", 1'b1, irq)
    regWrite(REG_STATUS, 32'h0000_0001);
    @(posedge clk_sys);
    #1 `CHK("irqClr", 1'b0, irq)
    regRead(8'h40, rd);
    `CHK("unmapped", 32'h0000_0000, rd)
    $display("test once done, mismatches %0d", badCount);
  endtask

  task automatic tCodes();
    logic [7:0]  codes [8] = '{8'h00, 8'h01, 8'h03, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h5A};
    logic [31:0] rd;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      statusIn <= codes[i];
      healthIn <= {4'h0, 3'b111, i[0]};
      weekIn <= 10'(i);
      msecIn <= i[1] ? 32'hFFFF_0000 : 32'h0000_1234;
      fracNsIn <= i[2] ? 32'h8000_0000 : 32'h7FFF_0000;
      regWrite(REG_CTRL, 32'h0000_0001);
      waitFrames(1);
      checkFrame();
      regRead(REG_COND, rd);
      `CHK("fixOk", codes[i] == 8'h00, rd[16])
    end
    $display("test codes done, mismatches %0d", badCount);
  endtask

  // Second request lands mid-frame and must be kept, not lost
  task automatic tBack();
    regWrite(REG_CTRL, 32'h0000_0001);
    repeat (20) @(posedge clk_sys);
    #1 `CHK("busy", 1'b1, busy)
    regWrite(REG_CTRL, 32'h0000_0001);
    waitFrames(2);
    checkFrame();
    $display("test back-to-back done, mismatches %0d", badCount);
  endtask

  task automatic tAuto();
    int n;
    regWrite(REG_CTRL, 32'h0000_0002);
    waitFrames(2);
    checkFrame();
    regWrite(REG_CTRL, 32'h0000_0000);
    repeat (400) @(posedge clk_sys);
    n = frameCount;
    repeat (400) @(posedge clk_sys);
    `CHK("autoOff", n, frameCount)
    $display("test auto done, mismatches %0d", badCount);
  endtask

  initial begin
    {rst_n, regWr, regRd, regAddr, regWdata} = '0;
    {weekIn, msecIn, fracNsIn, altitudeIn, statusIn, healthIn} = '0;
    {idx, frameCount, lastLen, cycles, badCount, samplesChecked} = '0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    tOnce();
    tCodes();
    tBack();
    tAuto();
    printVerdict();
  end
endmodule
